/* hdl/amd_cfg.svh */
// Constants for the addressing mode decoder: opcode classes, lengths,
// interrupt mask levels. Assumes inclusion by the package and modules.
`ifndef AMD_CFG_SVH
`define AMD_CFG_SVH

// Instruction lengths in bytes
`define AMD_LEN_ONE        3'h1
`define AMD_LEN_TWO        3'h2
`define AMD_LEN_THREE      3'h3
// Interrupt mask levels
`define AMD_MASK_LEVEL_HI  2'h3
`define AMD_MASK_LEVEL_LO  2'h0
// Zero-page upper byte
`define AMD_ZERO_PAGE_HI   8'h00
// Opcode high nibble that selects each addressing mode
`define AMD_NIB_IMM        4'ha
`define AMD_NIB_DIR_S      4'hb
`define AMD_NIB_DIR_L      4'hc
`define AMD_NIB_IDX_L      4'hd
`define AMD_NIB_IDX_S      4'he
`define AMD_NIB_IDX_N      4'hf
`define AMD_NIB_IND_S      4'h3
`define AMD_NIB_IND_L      4'h2
// Inherent opcode groups; the Y index is chosen by the use_y input
`define AMD_NIB_INH_A      4'h4
`define AMD_NIB_INH_B      4'h8
`define AMD_NIB_INH_C      4'h9

`endif

/* hdl/amd_pkg.sv */
// Types for the addressing mode decoder.
// Assumes amd_cfg.svh is on the include path.
`include "amd_cfg.svh"
package amd_pkg;
    // Addressing modes
    typedef enum logic [3:0] {
        AMD_INHERENT = 4'h0,
        AMD_IMMED    = 4'h1,
        AMD_DIR_S    = 4'h2,
        AMD_DIR_L    = 4'h3,
        AMD_IDX_N    = 4'h4,
        AMD_IDX_S    = 4'h5,
        AMD_IDX_L    = 4'h6,
        AMD_IND_S    = 4'h7,
        AMD_IND_L    = 4'h8
    } amd_mode_type;

    // Operations named by the decoder
    typedef enum logic [4:0] {
        OP_NONE                   = 5'h00,
        OP_LOAD                   = 5'h01,
        OP_COMPARE                = 5'h02,
        bit_compare_op            = 5'h03,
        OP_AND                    = 5'h04,
        OP_OR                     = 5'h05,
        OP_XOR                    = 5'h06,
        OP_ADD                    = 5'h07,
        OP_ADD_CARRY              = 5'h08,
        OP_SUB                    = 5'h09,
        sub_borrow_op             = 5'h0a,
        byte_multiply_op          = 5'h0b,
        OP_SWAP_NIB               = 5'h0c,
        OP_SHIFT_LL               = 5'h0d,
        OP_SHIFT_RL               = 5'h0e,
        OP_SHIFT_RA               = 5'h0f,
        OP_ROT_LC                 = 5'h10,
        OP_ROT_RC                 = 5'h11,
        OP_PUSH                   = 5'h12,
        OP_POP                    = 5'h13,
        stack_pointer_reset_op    = 5'h14,
        OP_TRAP                   = 5'h15,
        OP_RETURN                 = 5'h16,
        irq_return_op             = 5'h17,
        set_irq_mask_op           = 5'h18,
        clear_irq_mask_op         = 5'h19,
        wait_irq_op               = 5'h1a,
        OP_HALT                   = 5'h1b
    } amd_op_type;

    // Decode result for the fetch unit
    typedef struct packed {
        amd_mode_type mode;
        logic [2:0]   length;
        amd_op_type   op;
    } amd_dec_type;

    // Power state
    typedef enum logic [1:0] {
        PWR_RUN  = 2'b00,
        PWR_WAIT = 2'b01,
        PWR_HALT = 2'b10
    } amd_pwr_type;

    // Address decoder states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_PTR_H = 3'b001,
        ST_PTR_L = 3'b010,
        ST_DONE  = 3'b011
    } amd_st_type;
endpackage

/* hdl/amd_opdec.sv */
// Combinational opcode classifier: mode, length and operation.
// Assumes opcode is stable from a flop in the caller.
`timescale 1ns/1ps
`include "amd_cfg.svh"
module amd_opdec
(
    // Opcode in
    input  wire logic [7:0]          opcode,
    // Decode out
    output amd_pkg::amd_dec_type     dec
);
    // Classify by high nibble, operation by low nibble
    always_comb
    begin
        dec.mode   = amd_pkg::AMD_INHERENT;
        dec.length = `AMD_LEN_ONE;
        dec.op     = amd_pkg::OP_NONE;
        case (opcode[7:4])
            `AMD_NIB_IMM:
            begin
                dec.mode   = amd_pkg::AMD_IMMED;
                dec.length = `AMD_LEN_TWO;
            end
            `AMD_NIB_DIR_S:
            begin
                dec.mode   = amd_pkg::AMD_DIR_S;
                dec.length = `AMD_LEN_TWO;
            end
            `AMD_NIB_DIR_L:
            begin
                dec.mode   = amd_pkg::AMD_DIR_L;
                dec.length = `AMD_LEN_THREE;
            end
            `AMD_NIB_IDX_N:
            begin
                dec.mode   = amd_pkg::AMD_IDX_N;
                dec.length = `AMD_LEN_ONE;
            end
            `AMD_NIB_IDX_S:
            begin
                dec.mode   = amd_pkg::AMD_IDX_S;
                dec.length = `AMD_LEN_TWO;
            end
            `AMD_NIB_IDX_L:
            begin
                dec.mode   = amd_pkg::AMD_IDX_L;
                dec.length = `AMD_LEN_THREE;
            end
            `AMD_NIB_IND_S:
            begin
                dec.mode   = amd_pkg::AMD_IND_S;
                dec.length = `AMD_LEN_TWO;
            end
            `AMD_NIB_IND_L:
            begin
                dec.mode   = amd_pkg::AMD_IND_L;
                dec.length = `AMD_LEN_TWO;
            end
            default:
            begin
                dec.mode   = amd_pkg::AMD_INHERENT;
                dec.length = `AMD_LEN_ONE;
            end
        endcase
        // Memory and immediate forms share the ALU operation table
        if (opcode[7:4] != `AMD_NIB_INH_A && opcode[7:4] != `AMD_NIB_INH_B
            && opcode[7:4] != `AMD_NIB_INH_C && opcode[7:4] != 4'h0
            && opcode[7:4] != 4'h1 && opcode[7:4] != 4'h5
            && opcode[7:4] != 4'h6 && opcode[7:4] != 4'h7)
        begin
            case (opcode[3:0])
                4'h0:    dec.op = amd_pkg::OP_SUB;
                4'h1:    dec.op = amd_pkg::OP_COMPARE;
                4'h2:    dec.op = amd_pkg::sub_borrow_op;
                4'h4:    dec.op = amd_pkg::OP_AND;
                4'h5:    dec.op = amd_pkg::bit_compare_op;
                4'h6:    dec.op = amd_pkg::OP_LOAD;
                4'h8:    dec.op = amd_pkg::OP_XOR;
                4'h9:    dec.op = amd_pkg::OP_ADD_CARRY;
                4'ha:    dec.op = amd_pkg::OP_OR;
                4'hb:    dec.op = amd_pkg::OP_ADD;
                default: dec.op = amd_pkg::OP_NONE;
            endcase
        end
        else if (opcode[7:4] == `AMD_NIB_INH_A)
        begin
            case (opcode[3:0])
                4'h2:    dec.op = amd_pkg::byte_multiply_op;
                4'h4:    dec.op = amd_pkg::OP_SHIFT_RL;
                4'h6:    dec.op = amd_pkg::OP_ROT_RC;
                4'h7:    dec.op = amd_pkg::OP_SHIFT_RA;
                4'h8:    dec.op = amd_pkg::OP_SHIFT_LL;
                4'h9:    dec.op = amd_pkg::OP_ROT_LC;
                4'he:    dec.op = amd_pkg::OP_SWAP_NIB;
                default: dec.op = amd_pkg::OP_NONE;
            endcase
        end
        else if (opcode[7:4] == `AMD_NIB_INH_B)
        begin
            case (opcode[3:0])
                4'h0:    dec.op = amd_pkg::irq_return_op;
                4'h1:    dec.op = amd_pkg::OP_RETURN;
                4'h3:    dec.op = amd_pkg::OP_TRAP;
                4'h4:    dec.op = amd_pkg::OP_POP;
                4'h8:    dec.op = amd_pkg::OP_PUSH;
                4'he:    dec.op = amd_pkg::OP_HALT;
                4'hf:    dec.op = amd_pkg::wait_irq_op;
                default: dec.op = amd_pkg::OP_NONE;
            endcase
        end
        else if (opcode[7:4] == `AMD_NIB_INH_C)
        begin
            case (opcode[3:0])
                4'ha:    dec.op = amd_pkg::clear_irq_mask_op;
                4'hb:    dec.op = amd_pkg::set_irq_mask_op;
                4'hc:    dec.op = amd_pkg::stack_pointer_reset_op;
                default: dec.op = amd_pkg::OP_NONE;
            endcase
        end
    end
endmodule

/* hdl/amd_core.sv */
// Addressing mode decoder front end: latches an instruction, forms the
// effective address (reading pointers over the data bus) and tracks the
// interrupt mask and power state. Assumes the fetch unit presents whole
// instructions and the memory bus answers reads within the cycle of the read strobe.
`timescale 1ns/1ps
`include "amd_cfg.svh"

// Operation
// - Inherent instructions are one byte only
// - Immediate: opcode plus one operand byte
// - Direct short: one byte, zero page
// - Direct long: two address bytes, full space
// - Indexed address is unsigned index plus offset
// - Indexed no offset: index alone, no byte
// - Indexed short: byte offset, sum to 1FE
// - Indexed long: word offset, full space
// - Indirect: read pointer, then access operand
// - Indirect short: byte pointer, zero page
// - Indirect long: word pointer in zero page
// - Set mask to level 3, clear to 0
// - Wait idles until interrupt; halt stops oscillator
// - Multiply, swap, shifts and rotates decoded
// - Stack, trap and return operations decoded
module amd_core
(
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // Instruction from fetch unit
    input  wire logic                 ins_valid,
    input  wire logic [7:0]           ins_opcode,
    input  wire logic [7:0]           ins_byte1,
    input  wire logic [7:0]           ins_byte2,
    input  wire logic                 use_y,
    // Index registers
    input  wire logic [7:0]           idx_x,
    input  wire logic [7:0]           idx_y,
    // Interrupt request from core logic
    input  wire logic                 irq_pending,
    // Memory bus read port for pointers
    output logic                      mem_rd,
    output logic [15:0]               mem_addr,
    input  wire logic [7:0]           mem_rdata,
    // Result to fetch unit
    output logic                      ins_ready,
    output logic                      res_valid,
    output amd_pkg::amd_dec_type      res_dec,
    output logic [15:0]               res_ea,
    output logic [7:0]                res_imm,
    // Control state
    output logic [1:0]                irq_mask_level,
    output amd_pkg::amd_pwr_type      pwr_state,
    output logic                      osc_stop
);
    amd_pkg::amd_dec_type dec;            // Classifier output
    amd_pkg::amd_st_type  st_r;           // Address walk state
    amd_pkg::amd_dec_type dec_r;          // Latched decode
    logic [7:0]           ptr_r;          // Pointer location
    logic [7:0]           ptr_hi_r;       // Fetched high byte
    logic [15:0]          ea_nxt;         // Direct effective address
    logic [7:0]           idx_sel;        // Chosen index register

    amd_opdec u_opdec
    (
        .opcode (ins_opcode),
        .dec    (dec)
    );

    // Nine-bit index sum keeps the carry
    function automatic logic [15:0] idx_sum8(input logic [7:0] a,
                                             input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        idx_sum8 = {7'h00, s};
    endfunction

    assign idx_sel = use_y ? idx_y : idx_x;

    // Address for modes that need no memory read
    always_comb
    begin
        case (dec.mode)
            amd_pkg::AMD_DIR_S: ea_nxt = {`AMD_ZERO_PAGE_HI, ins_byte1};
            amd_pkg::AMD_DIR_L: ea_nxt = {ins_byte1, ins_byte2};
            amd_pkg::AMD_IDX_N: ea_nxt = {`AMD_ZERO_PAGE_HI, idx_sel};
            amd_pkg::AMD_IDX_S: ea_nxt = idx_sum8(idx_sel, ins_byte1);
            amd_pkg::AMD_IDX_L: ea_nxt = {ins_byte1, ins_byte2}
                                         + {8'h00, idx_sel};
            default:            ea_nxt = 16'h0000;
        endcase
    end

    // Only takes a new instruction when idle and awake
    assign ins_ready = (st_r == amd_pkg::ST_IDLE)
                       && (pwr_state == amd_pkg::PWR_RUN);

    // Address walk: pointer reads for indirect modes
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st_r      <= amd_pkg::ST_IDLE;
            dec_r     <= '0;
            ptr_r     <= 8'h00;
            ptr_hi_r  <= 8'h00;
            res_valid <= 1'b0;
            res_dec   <= '0;
            res_ea    <= 16'h0000;
            res_imm   <= 8'h00;
            mem_rd    <= 1'b0;
            mem_addr  <= 16'h0000;
        end
        else
        begin
            res_valid <= 1'b0;
            mem_rd    <= 1'b0;
            case (st_r)
                amd_pkg::ST_IDLE:
                begin
                    if (ins_valid && ins_ready)
                    begin
                        dec_r <= dec;
                        ptr_r <= ins_byte1;
                        // Immediate byte is the operand itself
                        res_imm <= (dec.mode == amd_pkg::AMD_IMMED)
                                   ? ins_byte1 : 8'h00;
                        if (dec.mode == amd_pkg::AMD_IND_S
                            || dec.mode == amd_pkg::AMD_IND_L)
                        begin
                            mem_rd   <= 1'b1;
                            mem_addr <= {`AMD_ZERO_PAGE_HI, ins_byte1};
                            st_r     <= (dec.mode == amd_pkg::AMD_IND_L)
                                        ? amd_pkg::ST_PTR_H
                                        : amd_pkg::ST_PTR_L;
                        end
                        else
                        begin
                            res_valid <= 1'b1;
                            res_dec   <= dec;
                            res_ea    <= ea_nxt;
                        end
                    end
                end
                amd_pkg::ST_PTR_H:
                begin
                    // High byte back; ask for the low byte next
                    ptr_hi_r <= mem_rdata;
                    mem_rd   <= 1'b1;
                    mem_addr <= {`AMD_ZERO_PAGE_HI, 8'(ptr_r + 8'h01)};
                    st_r     <= amd_pkg::ST_DONE;
                end
                amd_pkg::ST_PTR_L:
                begin
                    // One-byte pointer stays in zero page
                    res_valid <= 1'b1;
                    res_dec   <= dec_r;
                    res_ea    <= {`AMD_ZERO_PAGE_HI, mem_rdata};
                    st_r      <= amd_pkg::ST_IDLE;
                end
                amd_pkg::ST_DONE:
                begin
                    res_valid <= 1'b1;
                    res_dec   <= dec_r;
                    res_ea    <= {ptr_hi_r, mem_rdata};
                    st_r      <= amd_pkg::ST_IDLE;
                end
                default: st_r <= amd_pkg::ST_IDLE;
            endcase
        end
    end

    // Interrupt mask level
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            irq_mask_level <= `AMD_MASK_LEVEL_HI;
        else if (ins_valid && ins_ready)
        begin
            if (dec.op == amd_pkg::set_irq_mask_op)
                irq_mask_level <= `AMD_MASK_LEVEL_HI;
            else if (dec.op == amd_pkg::clear_irq_mask_op)
                irq_mask_level <= `AMD_MASK_LEVEL_LO;
        end
    end

    // Power state: wait leaves on interrupt, halt also stops oscillator
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            pwr_state <= amd_pkg::PWR_RUN;
        else if (pwr_state != amd_pkg::PWR_RUN)
        begin
            if (irq_pending)
                pwr_state <= amd_pkg::PWR_RUN;
        end
        else if (ins_valid && ins_ready)
        begin
            if (dec.op == amd_pkg::wait_irq_op)
                pwr_state <= amd_pkg::PWR_WAIT;
            else if (dec.op == amd_pkg::OP_HALT)
                pwr_state <= amd_pkg::PWR_HALT;
        end
    end

    assign osc_stop = (pwr_state == amd_pkg::PWR_HALT);
endmodule

/* verification/amd_core_asserts.sv */
// Port checker for the addressing mode decoder core.
// Assumes amd_pkg and amd_cfg.svh are compiled before this file.
`timescale 1ns/1ps
`include "amd_cfg.svh"
module amd_core_asserts
(
    // Clock and reset
    input wire logic                 mclk,
    input wire logic                 rst,
    // Instruction side
    input wire logic                 ins_valid,
    input wire logic [7:0]           ins_opcode,
    input wire logic [7:0]           ins_byte1,
    input wire logic                 use_y,
    input wire logic [7:0]           idx_x,
    input wire logic [7:0]           idx_y,
    input wire logic                 irq_pending,
    // Pointer reads
    input wire logic                 mem_rd,
    input wire logic [15:0]          mem_addr,
    // Results and state
    input wire logic                 ins_ready,
    input wire logic                 res_valid,
    input amd_pkg::amd_dec_type      res_dec,
    input wire logic [15:0]          res_ea,
    input wire logic [7:0]           res_imm,
    input wire logic [1:0]           irq_mask_level,
    input amd_pkg::amd_pwr_type      pwr_state,
    input wire logic                 osc_stop
);
    // Nine-bit short indexed sum, carry kept on purpose
    logic [8:0] sum9;
    assign sum9 = {1'b0, (use_y ? idx_y : idx_x)} + {1'b0, ins_byte1};

    // Length each mode must report
    function automatic logic [2:0] exp_len(input amd_pkg::amd_mode_type m);
        case (m)
            amd_pkg::AMD_INHERENT, amd_pkg::AMD_IDX_N: return 3'h1;
            amd_pkg::AMD_DIR_L, amd_pkg::AMD_IDX_L:    return 3'h3;
            default:                                   return 3'h2;
        endcase
    endfunction

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_len_mode: assert property (res_valid |->
        res_dec.length == exp_len(res_dec.mode)) else $error("bad length");
    a_imm_zero: assert property (res_valid &&
        res_dec.mode != amd_pkg::AMD_IMMED |-> res_imm == 8'h00)
        else $error("imm not zero");
    a_dir_take: assert property (ins_valid && ins_ready &&
        ins_opcode[7:4] == `AMD_NIB_DIR_S |=> res_valid &&
        res_dec.mode == amd_pkg::AMD_DIR_S &&
        res_ea == {8'h00, $past(ins_byte1)}) else $error("direct short");
    a_idx_short: assert property (ins_valid && ins_ready &&
        ins_opcode[7:4] == `AMD_NIB_IDX_S |=>
        res_ea == {7'h00, $past(sum9)}) else $error("indexed short sum");
    a_ptr_zero: assert property (mem_rd |->
        mem_addr[15:8] == 8'h00) else $error("pointer off zero page");
    a_ptr_next: assert property (mem_rd ##1 mem_rd |->
        mem_addr[7:0] == $past(mem_addr[7:0]) + 8'h01)
        else $error("pointer low byte address");
    a_mask_set: assert property (res_valid &&
        res_dec.op == amd_pkg::set_irq_mask_op |-> ##[0:1]
        irq_mask_level == 2'h3) else $error("mask not set");
    a_mask_clr: assert property (res_valid &&
        res_dec.op == amd_pkg::clear_irq_mask_op |-> ##[0:1]
        irq_mask_level == 2'h0) else $error("mask not cleared");
    a_halt_osc: assert property (osc_stop ==
        (pwr_state == amd_pkg::PWR_HALT)) else $error("oscillator stop");
    a_sleep_refuse: assert property (pwr_state != amd_pkg::PWR_RUN |->
        !ins_ready) else $error("ready while asleep");
    a_irq_wake: assert property (pwr_state != amd_pkg::PWR_RUN &&
        irq_pending |-> ##[1:3] pwr_state == amd_pkg::PWR_RUN)
        else $error("no wake");

    // Main scenarios reached
    c_ind_long: cover property (res_valid &&
        res_dec.mode == amd_pkg::AMD_IND_L);
    c_wait: cover property (pwr_state == amd_pkg::PWR_WAIT);
    c_halt: cover property (pwr_state == amd_pkg::PWR_HALT);
endmodule

bind amd_core amd_core_asserts u_chk (.mclk(mclk), .rst(rst),
    .ins_valid(ins_valid), .ins_opcode(ins_opcode), .ins_byte1(ins_byte1),
    .use_y(use_y), .idx_x(idx_x), .idx_y(idx_y),
    .irq_pending(irq_pending), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .ins_ready(ins_ready), .res_valid(res_valid), .res_dec(res_dec),
    .res_ea(res_ea), .res_imm(res_imm), .irq_mask_level(irq_mask_level),
    .pwr_state(pwr_state), .osc_stop(osc_stop));

/* verification/amd_mem_model.sv */
// Data memory model answering pointer reads in the strobe's own cycle.
// Assumes the core samples read data at the edge that ends its read pulse.
`timescale 1ns/1ps
module amd_mem_model
(
    // Clock and reset
    input wire logic          mclk,
    input wire logic          rst,
    // Read port
    input wire logic          mem_rd,
    input wire logic [15:0]   mem_addr,
    output logic [7:0]        mem_rdata
);
    logic [7:0]               idle_r;   // Inverse of the last bus value

    // Released bus shows the inverse of what it last carried, so a
    // sample outside the read cycle cannot pass by luck
    always @(posedge mclk or posedge rst)
        if (rst)
            idle_r <= 8'h00;
        else
            idle_r <= ~mem_rdata;

    // Content is a fixed pattern of the low address byte
    assign mem_rdata = mem_rd ? (mem_addr[7:0] ^ 8'hc3) : idle_r;
endmodule

/* verification/tb.sv */
// Self-checking bench for the decoder core with a memory model.
// Assumes amd_pkg, amd_cfg.svh, the core and the checker are compiled.
`timescale 1ns/1ps
module tb;
    // Expected result of one accepted instruction
    typedef struct {
        amd_pkg::amd_mode_type mode;
        logic [2:0]            len;
        logic [15:0]           ea;
        logic [7:0]            imm;
        bit                    ea_chk;
    } amd_note_type;

    logic                 mclk, rst, ins_valid, use_y, irq_pending;
    logic [7:0]           ins_opcode, ins_byte1, ins_byte2, idx_x, idx_y;
    logic                 mem_rd, ins_ready, res_valid, osc_stop;
    logic [15:0]          mem_addr, res_ea;
    logic [7:0]           mem_rdata, res_imm;
    logic [1:0]           irq_mask_level;
    amd_pkg::amd_dec_type res_dec;
    amd_pkg::amd_pwr_type pwr_state;
    amd_note_type         q[$];       // Notes waiting for results
    logic [1:0]           mq[$];      // Mask level due with each note
    logic [1:0]           exp_mask;   // Mask level after the last take
    int                   error_cnt, num_checks, cyc, i;
    logic [31:0]          seed, r, r2;
    logic [3:0]           nibs [8] = '{4'ha, 4'hb, 4'hc, 4'hd,
                                       4'he, 4'hf, 4'h3, 4'h2};

    amd_core dut (.mclk(mclk), .rst(rst), .ins_valid(ins_valid),
        .ins_opcode(ins_opcode), .ins_byte1(ins_byte1),
        .ins_byte2(ins_byte2), .use_y(use_y), .idx_x(idx_x), .idx_y(idx_y),
        .irq_pending(irq_pending), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .ins_ready(ins_ready),
        .res_valid(res_valid), .res_dec(res_dec), .res_ea(res_ea),
        .res_imm(res_imm), .irq_mask_level(irq_mask_level),
        .pwr_state(pwr_state), .osc_stop(osc_stop));
    amd_mem_model mem_model (.mclk(mclk), .rst(rst), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata));

    // 250 MHz clock
    always #2 mclk = ~mclk;

    // Fixed-seed xorshift source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Memory content as the model holds it
    function automatic logic [7:0] pm(input logic [7:0] a);
        return a ^ 8'hc3;
    endfunction

    // One value comparison, counted
    task automatic cmp(input string nm, input logic [15:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            $display("MISMATCH %s exp %h got %h", nm, e, g);
            error_cnt++;
        end
    endtask

    // Present one instruction, hold it until taken, note the expectation
    task automatic send(input logic [7:0] op, b1, b2,
                        input logic y, input logic [7:0] xv, yv);
        amd_note_type n;
        logic [7:0]   ix;
        int           w;
        ix = y ? yv : xv;
        case (op[7:4])
            4'ha: n = '{amd_pkg::AMD_IMMED, 3'h2, 16'h0, b1, 1'b0};
            4'hb: n = '{amd_pkg::AMD_DIR_S, 3'h2, {8'h00, b1}, 8'h0, 1'b1};
            4'hc: n = '{amd_pkg::AMD_DIR_L, 3'h3, {b1, b2}, 8'h0, 1'b1};
            4'hd: n = '{amd_pkg::AMD_IDX_L, 3'h3, {b1, b2} + {8'h00, ix},
                        8'h0, 1'b1};
            4'he: n = '{amd_pkg::AMD_IDX_S, 3'h2, {8'h00, ix} + {8'h00, b1},
                        8'h0, 1'b1};
            4'hf: n = '{amd_pkg::AMD_IDX_N, 3'h1, {8'h00, ix}, 8'h0, 1'b1};
            4'h3: n = '{amd_pkg::AMD_IND_S, 3'h2, {8'h00, pm(b1)},
                        8'h0, 1'b1};
            4'h2: n = '{amd_pkg::AMD_IND_L, 3'h2,
                        {pm(b1), pm(b1 + 8'h01)}, 8'h0, 1'b1};
            default: n = '{amd_pkg::AMD_INHERENT, 3'h1, 16'h0, 8'h0, 1'b0};
        endcase
        // Mask operations move the level, all others leave it
        if (op == 8'h9b)
            exp_mask = 2'h3;
        else if (op == 8'h9a)
            exp_mask = 2'h0;
        ins_opcode = op;
        ins_byte1 = b1;
        ins_byte2 = b2;
        use_y = y;
        idx_x = xv;
        idx_y = yv;
        ins_valid = 1'b1;
        for (w = 0; w < 200 && ins_ready !== 1'b1; w++)
            @(posedge mclk) #1;
        q.push_back(n);
        mq.push_back(exp_mask);
        @(posedge mclk) #1;
    endtask

    // Wake from wait or halt once the core sleeps
    always @(posedge mclk)
        #1 irq_pending = (pwr_state != amd_pkg::PWR_RUN);

    // Result watcher: oldest note against each result
    always @(posedge mclk)
    begin
        amd_note_type n;
        #1;
        if (res_valid === 1'b1)
        begin
            if (q.size() == 0)
                cmp("spare result", 16'h1, 16'h0);
            else
            begin
                n = q.pop_front();
                cmp("mode", n.mode, res_dec.mode);
                cmp("length", n.len, res_dec.length);
                cmp("imm", n.imm, res_imm);
                cmp("mask", mq.pop_front(), irq_mask_level);
                if (n.ea_chk)
                    cmp("ea", n.ea, res_ea);
            end
        end
    end

    // Hang guard
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            summarize();
        end
    end

    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        {mclk, ins_valid, use_y, irq_pending} = 4'h0;
        {ins_opcode, ins_byte1, ins_byte2, idx_x, idx_y} = 40'h0;
        rst = 1'b1;
        seed = 32'h12;
        exp_mask = 2'h3;
        repeat (6) @(posedge mclk);
        #1 rst = 1'b0;
        cmp("mask reset", 16'h3, {14'h0, irq_mask_level});
        // Boundaries: carry to 1FE, long wrap, zero-page pointer wrap
        send(8'he0, 8'hff, 8'h00, 1'b0, 8'hff, 8'h00);
        send(8'hd1, 8'hff, 8'hff, 1'b1, 8'h00, 8'h01);
        send(8'h20, 8'hff, 8'h00, 1'b0, 8'h00, 8'h00);
        send(8'hf2, 8'h5a, 8'ha5, 1'b1, 8'h00, 8'hff);
        send(8'h30, 8'h80, 8'h00, 1'b0, 8'h00, 8'h00);
        // Every addressing mode except inherent, random bytes, back to back
        for (i = 0; i < 64; i++)
        begin
            r = xs();
            r2 = xs();
            send({nibs[i % 8], r[3:0]}, r[15:8], r[23:16], r[4],
                 r[31:24], r2[7:0]);
        end
        // All opcodes of the 4, 8 and 9 inherent groups, including sleep and mask operations
        for (i = 0; i < 48; i++)
        begin
            r = xs();
            send({(i < 16) ? 4'h4 : (i < 32) ? 4'h8 : 4'h9, i[3:0]},
                 r[7:0], r[15:8], r[16], r[31:24], r[23:16]);
        end
        ins_valid = 1'b0;
        repeat (10) @(posedge mclk);
        cmp("left notes", 16'h0, 16'(q.size()));
        summarize();
    end
endmodule
